// File: hdl/bcr_pkg.sv
// Constants, carrier types and state layout of the bridge configuration header bank
// How it works
// - Programming-interface byte reads 00h, or 01h while legacy subtractive decode is set.
// - Sub-class byte, bits 23:16, is read-only and returns 04h.
// - Base class byte, bits 31:24, is read-only and returns 06h.
// - Line size bits 1:0 and 7:6 read zero and ignore writes.
// - Line size bits 5:2 are writable, reset to zero, select 0 to 60 dwords in steps of 4.
// - Upstream latency timer, bits 15:8, is read-only and returns 00h.
// - Header layout reads 01h: bridge layout, single function.
// - Upstream, downstream and highest bus numbers are writable bytes resetting to 00h.
// - Downstream latency timer, bits 31:24, is writable and resets to 40h.
// - I/O base and limit capability fields read 01 for 32-bit I/O.
// - I/O base bits 7:4 writable, reset zero; bits 3:2 read zero.
// - I/O limit bits 15:12 writable, reset zero; bits 11:10 read zero.
package bcr_pkg;

   // Byte addresses of the decoded words and of the two reserved words
   localparam logic [7:0] OFS_CLASS    = 8'h08;
   localparam logic [7:0] OFS_LINE     = 8'h0c;
   localparam logic [7:0] OFS_RSVD0    = 8'h10;
   localparam logic [7:0] OFS_RSVD1    = 8'h14;
   localparam logic [7:0] OFS_BUS      = 8'h18;
   localparam logic [7:0] OFS_IO       = 8'h1c;

   // Fixed field values
   localparam logic [7:0] PROGIF_PLAIN = 8'h00;
   localparam logic [7:0] PROGIF_SUBTR = 8'h01;
   localparam logic [7:0] SUBCLASS_VAL = 8'h04;
   localparam logic [7:0] BASECLASS_VAL = 8'h06;
   localparam logic [7:0] PRI_LAT_VAL  = 8'h00;
   localparam logic [7:0] HDR_VAL      = 8'h01;
   localparam logic [7:0] SELFTEST_VAL = 8'h00;
   localparam logic [1:0] IO_CAP_VAL   = 2'h1;

   // Reset values of writable fields
   localparam logic [3:0] LINE_RST     = 4'h0;
   localparam logic [7:0] BUS_RST      = 8'h00;
   localparam logic [7:0] SEC_LAT_RST  = 8'h40;
   localparam logic [3:0] IO_BASE_RST  = 4'h0;
   localparam logic [3:0] IO_LIM_RST   = 4'h0;

   // Field positions inside their words
   localparam int LINE_LSB     = 2;
   localparam int IO_BASE_LSB  = 4;
   localparam int IO_LIM_LSB   = 12;

   // Routing fields handed to the rest of the bridge
   typedef struct packed {
      logic [3:0] line_size;
      logic [7:0] upstream_bus_num;
      logic [7:0] downstream_bus_num;
      logic [7:0] highest_bus_num;
      logic [7:0] downstream_latency_timer;
      logic [3:0] io_window_base;
      logic [3:0] io_window_limit;
   } bcr_route_t;

   // Whole state of the bank
   typedef struct packed {
      bcr_route_t  route;
      logic [31:0] rdata;
   } bcr_state_t;

endpackage : bcr_pkg

// File: hdl/bcr_regs.sv
// Bridge configuration header bank, offsets 08h to 1Ch
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module bcr_regs #(
   parameter int         ADDR_W   = 8,
   parameter logic [7:0] REVISION = 8'h5a   // Arbitrary value
) (
   // Clock, reset, enable
   input  wire logic                ref_clk,
   input  wire logic                rstn,
   input  wire logic                clk_en,
   // Register port
   input  wire logic [ADDR_W-1:0]   addr,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          byte_en,
   input  wire logic                wr_stb,
   input  wire logic                rd_stb,
   output logic      [31:0]         rdata,
   // Legacy subtractive-decode bit, held in another register
   input  wire logic                legacy_subtractive,
   // Routing fields
   output bcr_pkg::bcr_route_t      route
);
   import bcr_pkg::*;

   if (ADDR_W < 8) begin : g_addr_check
      $error("bcr_regs: ADDR_W must be at least 8");
   end

   bcr_state_t state_q;
   bcr_state_t state_d;

   // Word hit: upper address bits must be zero, low two bits are ignored
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(ofs));
   endfunction : hit

   // Byte-lane merge of a whole 8-bit lane
   function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                        input logic en);
      lane = en ? nw : old;
   endfunction : lane

   logic [7:0] progif;
   assign progif = legacy_subtractive ? PROGIF_SUBTR : PROGIF_PLAIN;

   always_comb begin
      state_d       = state_q;
      state_d.rdata = 32'h0000_0000;
      if (wr_stb) begin
         // Only the listed writable bits are stored; writes leave every other bit unchanged
         if (hit(addr, OFS_LINE)) begin
            if (byte_en[0]) begin
               state_d.route.line_size = wdata[LINE_LSB +: 4];
            end
         end else if (hit(addr, OFS_BUS)) begin
            state_d.route.upstream_bus_num =
               lane(state_q.route.upstream_bus_num, wdata[7:0], byte_en[0]);
            state_d.route.downstream_bus_num =
               lane(state_q.route.downstream_bus_num, wdata[15:8], byte_en[1]);
            state_d.route.highest_bus_num =
               lane(state_q.route.highest_bus_num, wdata[23:16], byte_en[2]);
            state_d.route.downstream_latency_timer =
               lane(state_q.route.downstream_latency_timer, wdata[31:24], byte_en[3]);
         end else if (hit(addr, OFS_IO)) begin
            if (byte_en[0]) begin
               state_d.route.io_window_base = wdata[IO_BASE_LSB +: 4];
            end
            if (byte_en[1]) begin
               state_d.route.io_window_limit = wdata[IO_LIM_LSB +: 4];
            end
         end
      end
      if (rd_stb) begin
         // Unmapped words, reserved words among them, read as zero
         if (hit(addr, OFS_CLASS)) begin
            state_d.rdata = {BASECLASS_VAL, SUBCLASS_VAL, progif, REVISION};
         end else if (hit(addr, OFS_LINE)) begin
            state_d.rdata = {SELFTEST_VAL, HDR_VAL, PRI_LAT_VAL,
                             2'b00, state_q.route.line_size, 2'b00};
         end else if (hit(addr, OFS_BUS)) begin
            state_d.rdata = {state_q.route.downstream_latency_timer,
                             state_q.route.highest_bus_num,
                             state_q.route.downstream_bus_num,
                             state_q.route.upstream_bus_num};
         end else if (hit(addr, OFS_IO)) begin
            // Upper half belongs to the secondary status word, kept elsewhere
            state_d.rdata = {16'h0000,
                             state_q.route.io_window_limit, 2'b00, IO_CAP_VAL,
                             state_q.route.io_window_base, 2'b00, IO_CAP_VAL};
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_q.route.line_size                <= LINE_RST;
         state_q.route.upstream_bus_num         <= BUS_RST;
         state_q.route.downstream_bus_num       <= BUS_RST;
         state_q.route.highest_bus_num          <= BUS_RST;
         state_q.route.downstream_latency_timer <= SEC_LAT_RST;
         state_q.route.io_window_base           <= IO_BASE_RST;
         state_q.route.io_window_limit          <= IO_LIM_RST;
         state_q.rdata                          <= 32'h0000_0000;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   assign rdata = state_q.rdata;
   assign route = state_q.route;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence s_rd(logic [7:0] ofs);
      clk_en && rd_stb && hit(addr, ofs);
   endsequence
   sequence s_wr(logic [7:0] ofs, int b);
      clk_en && wr_stb && hit(addr, ofs) && byte_en[b];
   endsequence

   a_progif_legacy: assert property (s_rd(OFS_CLASS) |=>
      rdata[15:8] == ($past(legacy_subtractive) ? 8'h01 : 8'h00))
      else $error("programming interface byte wrong");
   a_class_fixed: assert property (s_rd(OFS_CLASS) |=>
      rdata[23:16] == SUBCLASS_VAL) else $error("sub-class byte wrong");
   a_base_class: assert property (s_rd(OFS_CLASS) |=>
      rdata[31:24] == BASECLASS_VAL) else $error("base class byte wrong");
   a_line_unused: assert property (s_rd(OFS_LINE) |=>
      rdata[1:0] == 2'b00 && rdata[7:6] == 2'b00) else $error("unused line bits set");
   a_line_write: assert property (s_wr(OFS_LINE, 0) |=>
      route.line_size == $past(wdata[5:2]))
      else $error("line size not stored");
   a_hdr_lat: assert property (s_rd(OFS_LINE) |=>
      rdata[15:8] == 8'h00 && rdata[23:16] == 8'h01) else $error("latency or header wrong");
   a_hdr_layout: assert property (s_rd(OFS_LINE) |=>
      rdata[22:16] == 7'h01 && !rdata[23]) else $error("header layout wrong");
   a_bus_write: assert property (s_wr(OFS_BUS, 1) |=>
      route.downstream_bus_num == $past(wdata[15:8])) else $error("bus number not stored");
   a_lat_hold: assert property (!(clk_en && wr_stb && hit(addr, OFS_BUS) && byte_en[3])
      |=> $stable(route.downstream_latency_timer)) else $error("latency timer moved");
   a_io_cap: assert property (s_rd(OFS_IO) |=>
      rdata[1:0] == 2'b01 && rdata[9:8] == 2'b01 && rdata[3:2] == 2'b00
      && rdata[11:10] == 2'b00) else $error("I/O capability bits wrong");
   a_io_base: assert property (s_wr(OFS_IO, 0) |=>
      route.io_window_base == $past(wdata[7:4])) else $error("I/O base not stored");
   a_io_limit: assert property (s_wr(OFS_IO, 1) |=>
      route.io_window_limit == $past(wdata[15:12])) else $error("I/O limit not stored");
   a_lane_guard: assert property (clk_en && wr_stb && hit(addr, OFS_IO) && !byte_en[1]
      |=> $stable(route.io_window_limit)) else $error("limit changed without enable");
   a_rdata_pulse: assert property (clk_en && !rd_stb |=> rdata == 32'h0)
      else $error("read data outside read slot");

   // Per-lane write strokes seen by the checks
   logic [3:0] lane_wr;
   for (genvar g = 0; g < 4; g++) begin : g_lane
      assign lane_wr[g] = clk_en && wr_stb && byte_en[g];
   end

   // Any decoded word of this bank
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, OFS_CLASS) || hit(a, OFS_LINE) || hit(a, OFS_BUS) || hit(a, OFS_IO);
   endfunction : mapped

   // Two sampled edges in reset: the flops hold their reset values by then
   sequence s_held;
      !rstn ##1 !rstn;
   endsequence

   // Frozen enable and quiet cycles
   a_freeze_route: assert property (
      !clk_en
      |=> $stable(route))
      else $error("routing moved while frozen");

   a_freeze_rdata: assert property (
      !clk_en
      |=> $stable(rdata))
      else $error("read data moved while frozen");

   a_quiet_route: assert property (
      !(clk_en && wr_stb)
      |=> $stable(route))
      else $error("routing moved without a write");

   a_hole_write: assert property (
      clk_en && wr_stb && !mapped(addr)
      |=> $stable(route))
      else $error("unmapped write had an effect");

   a_hole_read: assert property (
      clk_en && rd_stb && !mapped(addr)
      |=> rdata == 32'h0)
      else $error("unmapped read not zero");

   a_class_write: assert property (
      clk_en && wr_stb && hit(addr, OFS_CLASS)
      |=> $stable(route))
      else $error("class word write had an effect");

   a_read_keeps: assert property (
      clk_en && rd_stb
      |=> $stable(route))
      else $error("read moved routing");

   // Line size word
   a_line_lane: assert property (
      lane_wr[0] && hit(addr, OFS_LINE)
      |=> route.line_size == $past(wdata[LINE_LSB +: 4]))
      else $error("line size lane not stored");

   a_line_keep: assert property (
      !(lane_wr[0] && hit(addr, OFS_LINE))
      |=> $stable(route.line_size))
      else $error("line size moved without its lane");

   a_line_read: assert property (
      s_rd(OFS_LINE)
      |=> rdata[5:2] == route.line_size)
      else $error("line size read back wrong");

   a_line_low: assert property (
      s_rd(OFS_LINE)
      |=> rdata[1:0] == 2'b00)
      else $error("line size low bits set");

   a_line_high: assert property (
      s_rd(OFS_LINE)
      |=> rdata[7:6] == 2'b00)
      else $error("line size high bits set");

   a_pri_lat: assert property (
      s_rd(OFS_LINE)
      |=> rdata[15:8] == PRI_LAT_VAL)
      else $error("upstream latency timer wrong");

   a_hdr_single: assert property (
      s_rd(OFS_LINE)
      |=> rdata[23] == 1'b0)
      else $error("multi-function bit set");

   a_selftest: assert property (
      s_rd(OFS_LINE)
      |=> rdata[31:24] == SELFTEST_VAL)
      else $error("self-test byte wrong");

   // Class word
   a_revision: assert property (
      s_rd(OFS_CLASS)
      |=> rdata[7:0] == REVISION)
      else $error("revision byte wrong");

   a_progif_set: assert property (
      s_rd(OFS_CLASS) ##0 legacy_subtractive
      |=> rdata[15:8] == PROGIF_SUBTR)
      else $error("programming interface not 01h");

   a_progif_clear: assert property (
      s_rd(OFS_CLASS) ##0 !legacy_subtractive
      |=> rdata[15:8] == PROGIF_PLAIN)
      else $error("programming interface not 00h");

   a_class_word: assert property (
      s_rd(OFS_CLASS)
      |=> rdata[31:16] == {BASECLASS_VAL, SUBCLASS_VAL})
      else $error("class bytes wrong");

   // Bus number word
   a_up_write: assert property (
      s_wr(OFS_BUS, 0)
      |=> route.upstream_bus_num == $past(wdata[7:0]))
      else $error("upstream bus number not stored");

   a_high_write: assert property (
      s_wr(OFS_BUS, 2)
      |=> route.highest_bus_num == $past(wdata[23:16]))
      else $error("highest bus number not stored");

   a_lat_write: assert property (
      s_wr(OFS_BUS, 3)
      |=> route.downstream_latency_timer == $past(wdata[31:24]))
      else $error("latency timer not stored");

   a_up_keep: assert property (
      !(lane_wr[0] && hit(addr, OFS_BUS))
      |=> $stable(route.upstream_bus_num))
      else $error("upstream bus number moved");

   a_down_keep: assert property (
      !(lane_wr[1] && hit(addr, OFS_BUS))
      |=> $stable(route.downstream_bus_num))
      else $error("downstream bus number moved");

   a_high_keep: assert property (
      !(lane_wr[2] && hit(addr, OFS_BUS))
      |=> $stable(route.highest_bus_num))
      else $error("highest bus number moved");

   a_bus_read: assert property (
      s_rd(OFS_BUS)
      |=> rdata == {route.downstream_latency_timer, route.highest_bus_num,
                    route.downstream_bus_num, route.upstream_bus_num})
      else $error("bus word read back wrong");

   // I/O window word
   a_base_keep: assert property (
      !(lane_wr[0] && hit(addr, OFS_IO))
      |=> $stable(route.io_window_base))
      else $error("I/O base moved without its lane");

   a_io_read_base: assert property (
      s_rd(OFS_IO)
      |=> rdata[7:4] == route.io_window_base)
      else $error("I/O base read back wrong");

   a_io_read_lim: assert property (
      s_rd(OFS_IO)
      |=> rdata[15:12] == route.io_window_limit)
      else $error("I/O limit read back wrong");

   a_cap_base: assert property (
      s_rd(OFS_IO)
      |=> rdata[1:0] == IO_CAP_VAL)
      else $error("I/O base capability wrong");

   a_cap_limit: assert property (
      s_rd(OFS_IO)
      |=> rdata[9:8] == IO_CAP_VAL)
      else $error("I/O limit capability wrong");

   a_io_upper: assert property (
      s_rd(OFS_IO)
      |=> rdata[31:16] == 16'h0000)
      else $error("I/O word upper half not zero");

   // Reset values, checked while reset is held
   a_line_rst: assert property (disable iff (1'b0)
      s_held
      |-> route.line_size == LINE_RST)
      else $error("line size reset wrong");

   a_up_rst: assert property (disable iff (1'b0)
      s_held
      |-> route.upstream_bus_num == BUS_RST)
      else $error("upstream bus number reset wrong");

   a_down_rst: assert property (disable iff (1'b0)
      s_held
      |-> route.downstream_bus_num == BUS_RST)
      else $error("downstream bus number reset wrong");

   a_high_rst: assert property (disable iff (1'b0)
      s_held
      |-> route.highest_bus_num == BUS_RST)
      else $error("highest bus number reset wrong");

   a_lat_rst: assert property (disable iff (1'b0)
      s_held
      |-> route.downstream_latency_timer == SEC_LAT_RST)
      else $error("latency timer reset wrong");

   a_base_rst: assert property (disable iff (1'b0)
      s_held
      |-> route.io_window_base == IO_BASE_RST)
      else $error("I/O base reset wrong");

   a_lim_rst: assert property (disable iff (1'b0)
      s_held
      |-> route.io_window_limit == IO_LIM_RST)
      else $error("I/O limit reset wrong");

   a_rdata_rst: assert property (disable iff (1'b0)
      s_held
      |-> rdata == 32'h0)
      else $error("read data reset wrong");

endmodule : bcr_regs
`default_nettype wire

// File: tb/bcr_regs_bench.sv
// Self-checking bench of the bridge configuration header bank
`timescale 1ns/1ps
`default_nettype none
module bcr_regs_bench;
   import bcr_pkg::*;
   localparam logic [7:0] REV = 8'h3c;   // Arbitrary value
   logic             ref_clk = 1'b0;
   logic             rstn    = 1'b0;
   logic             clk_en  = 1'b1;
   logic [7:0]       addr    = 8'h00;
   logic [31:0]      wdata   = 32'h0;
   logic [3:0]       byte_en = 4'h0;
   logic             wr_stb  = 1'b0;
   logic             rd_stb  = 1'b0;
   logic             legacy  = 1'b0;
   logic [31:0]      rdata;
   bcr_route_t       route;
   int               n_errors = 0;
   int               compares = 0;

   always #5 ref_clk = ~ref_clk;

   bcr_regs #(.ADDR_W(8), .REVISION(REV)) i_dut (
      .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .addr(addr), .wdata(wdata),
      .byte_en(byte_en), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .legacy_subtractive(legacy), .route(route));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Strobe stands one cycle; the edge after it takes the request
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      addr <= a; wdata <= d; byte_en <= be; wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      addr <= a; rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1;
      check(rdata, exp);
   endtask : rd

   task automatic final_report;
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report

   initial begin
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      #1;
      check(route, 44'h000_0000_4000);
      rd(8'h08, {8'h06, 8'h04, 8'h00, REV});
      legacy <= 1'b1;
      rd(8'h08, {8'h06, 8'h04, 8'h01, REV});
      rd(8'h0c, 32'h0001_0000);
      rd(8'h18, 32'h4000_0000);
      rd(8'h1c, 32'h0000_0101);
      @(posedge ref_clk);
      #1;
      check(rdata, 32'h0);
      $display("reset values done");
      // All ones to every mapped word: only writable bits may take them
      wr(8'h08, 32'hffff_ffff, 4'hf);
      wr(8'h0c, 32'hffff_ffff, 4'hf);
      wr(8'h18, 32'hffff_ffff, 4'hf);
      wr(8'h1c, 32'hffff_ffff, 4'hf);
      check(route, 44'hfff_ffff_ffff);
      legacy <= 1'b0;
      rd(8'h08, {8'h06, 8'h04, 8'h00, REV});
      rd(8'h0c, 32'h0001_003c);
      rd(8'h18, 32'hffff_ffff);
      rd(8'h1c, 32'h0000_f1f1);
      $display("read-only bits done");
      // Lane writes touch only the enabled bytes
      wr(8'h18, 32'h1122_3344, 4'h5);
      wr(8'h0c, 32'h0000_0024, 4'he);
      check(route, 44'hf44_ff22_ffff);
      rd(8'h18, 32'hff22_ff44);
      wr(8'h0c, 32'h0000_0024, 4'h1);
      rd(8'h0c, 32'h0001_0024);
      $display("byte enables done");
      // Frozen clock enable and holes in the map swallow writes
      clk_en <= 1'b0;
      wr(8'h18, 32'h0, 4'hf);
      clk_en <= 1'b1;
      wr(8'h20, 32'h0, 4'hf);
      wr(8'h10, 32'hffff_ffff, 4'hf);
      rd(8'h18, 32'hff22_ff44);
      rd(8'h10, 32'h0);
      rd(8'h14, 32'h0);
      rd(8'h40, 32'h0);
      $display("ignored accesses done");
      final_report();
   end

   initial begin
      #20000;
      n_errors++;
      final_report();
   end
endmodule : bcr_regs_bench
`default_nettype wire
